//--- rtl/irq_tb_pkg.sv
// Constants shared by the interrupt and time base block.
// Assumes an 8-bit register port and a 125 MHz system clock.
package irq_tb_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CONV_W = 12;
	localparam int SRC_N = 8;
	localparam int GRP_N = 4;
	localparam int VEC_W = 3;
	localparam int TB_CNT_W = 15;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_SRC_FLAG = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_PT_FLAG = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_SRC_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PT_EN = 8'h05;
	localparam logic [ADDR_W-1:0] OFS_UB_LO = 8'h06;
	localparam logic [ADDR_W-1:0] OFS_UB_HI = 8'h07;
	localparam logic [ADDR_W-1:0] OFS_LB_LO = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LB_HI = 8'h09;
	localparam logic [ADDR_W-1:0] OFS_TICK_CTRL = 8'h0a;
	localparam logic [ADDR_W-1:0] OFS_PSC_SRC = 8'h0b;
	localparam logic [DATA_W-1:0] PSC_SRC_RESET = 8'h00;
	localparam logic [1:0] PSC_SYS = 2'h0;
	localparam logic [1:0] PSC_SYS_DIV4 = 2'h1;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [TB_CNT_W:0] TB_BASE_MASK = 16'h0100;
	localparam logic [VEC_W-1:0] VEC_PROT = 3'h0;
	localparam logic [VEC_W-1:0] VEC_GRP0 = 3'h1;
	localparam logic [VEC_W-1:0] VEC_GRP2 = 3'h3;
	localparam logic [VEC_W-1:0] VEC_TICK = 3'h5;
	localparam int GRP_PWM = 2;
	localparam int GRP_PT = 3;
endpackage

//--- rtl/irq_timebase.sv
// Interrupt request logic and time base tick generator.
// Assumes synchronous event pulses and an 8-bit strobed register port.
// Notes on behaviour
// - Motor protection signal sets the protection request flag.
// - Protection vector needs flag, global enable, protection enable and a free stack.
// - Servicing protection clears its flag and the global enable.
// - Any enabled source flag of a group sets that group's request flag.
// - Group vector needs group flag, global and group enables, free stack.
// - Group service clears group flag and global enable; software clears source flags.
// - Converter limit request follows above-upper and below-lower compare enables.
// - Conversion end sets done flag; vectoring needs global, group, source enables.
// - Capture overflow and compare set their flags, feeding group one.
// - One period-match and three duty-match PWM requests feed group two.
// - PWM group service clears group flag and global enable only.
// - Periodic timer owns A and P match flags with an enable each.
// - Timer request pends only when a match flag and group flag are set.
// - Divider overflow sets tick flag; service clears it.
// - Tick vector needs global and tick enables and a free stack.
// - Tick period comes from dividing the prescaler clock by a selectable ratio.
// - Source 00 system clock, 01 system clock over four, 1x sub clock.
// - Prescaler select bits seven to two read zero.
// - Period codes 000 to 111 give two to the eight through fifteen.
// - Any flag rising wakes the device regardless of enables.
// - Return-from-interrupt sets the global enable; plain return does not.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module irq_timebase
	import irq_tb_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	input wire logic i_motor_protect_signal,
	input wire logic i_conv_done,
	input wire logic [CONV_W-1:0] i_conv_result,
	input wire logic i_capture_ovf,
	input wire logic i_capture_cmp,
	input wire logic i_pwm_period_match,
	input wire logic [2:0] i_pwm_duty_match,
	input wire logic i_ptimer_a_match,
	input wire logic i_ptimer_p_match,
	input wire logic i_sub_clk_tick,
	input wire logic i_stack_full,
	input wire logic i_return_from_irq,
	output logic o_vector_valid,
	output logic [VEC_W-1:0] o_vector,
	output logic o_global_irq_en,
	output logic o_wake
);
	typedef struct packed {
		logic global_irq_en;
		logic protect_irq_en;
		logic tick_irq_en;
		logic [GRP_N-1:0] grp_en;
		logic protect_req_flag;
		logic tick_req_flag;
		logic [GRP_N-1:0] group_req_flag;
		logic [SRC_N-1:0] src_flag;
		logic [SRC_N-1:0] src_en;
		logic [1:0] pt_flag;
		logic [1:0] pt_en;
		logic above_upper_cmp_en;
		logic below_lower_cmp_en;
		logic [CONV_W-1:0] upper_bound;
		logic [CONV_W-1:0] lower_bound;
		logic tick_on;
		logic [2:0] tick_period_sel;
		logic [1:0] prescaler_src_sel;
		logic [1:0] div4;
		logic [TB_CNT_W-1:0] tick_cnt;
		logic [DATA_W-1:0] rdata;
		logic vec_valid;
		logic [VEC_W-1:0] vec;
		logic wake;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic limit_hit;
	logic [SRC_N-1:0] src_set;
	logic [GRP_N-1:0] grp_set;
	logic [5:0] pend;
	logic psc_pulse;
	logic [TB_CNT_W:0] tb_mask;
	logic tb_ovf;
	logic [15:0] old_flags;
	logic [15:0] new_flags;

	// Limit compare is judged only on the done strobe, so a stale result never retriggers.
	assign limit_hit = i_conv_done && ((s_r.above_upper_cmp_en && i_conv_result > s_r.upper_bound)
		|| (s_r.below_lower_cmp_en && i_conv_result < s_r.lower_bound));
	assign src_set = {i_pwm_duty_match, i_pwm_period_match, i_capture_cmp, i_capture_ovf,
		limit_hit, i_conv_done};

	// Groups 0 to 2 each collect a contiguous slice of the source flags; group 3 takes the timer matches.
	genvar g;
	generate
		for (g = 0; g < GRP_N - 1; g++)
		begin : grp_gen
			if (g == GRP_PWM)
			begin : pwm_g
				assign grp_set[g] = |(src_set[SRC_N-1:4] & s_r.src_en[SRC_N-1:4]);
			end
			else
			begin : pair_g
				assign grp_set[g] = |(src_set[2*g+1 -: 2] & s_r.src_en[2*g+1 -: 2]);
			end
		end
	endgenerate
	assign grp_set[GRP_PT] = |({i_ptimer_p_match, i_ptimer_a_match} & s_r.pt_en);

	assign pend[0] = s_r.protect_req_flag && s_r.protect_irq_en;
	assign pend[GRP_N:1] = s_r.group_req_flag & s_r.grp_en;
	assign pend[5] = s_r.tick_req_flag && s_r.tick_irq_en;

	// A slow prescaler only ever stretches the divider; one counter covers every ratio.
	always_comb
	begin
		case (s_r.prescaler_src_sel)
			PSC_SYS: psc_pulse = 1'b1;
			PSC_SYS_DIV4: psc_pulse = (s_r.div4 == DIV4_LAST);
			default: psc_pulse = i_sub_clk_tick;
		endcase
	end
	assign tb_mask = (TB_BASE_MASK << s_r.tick_period_sel) - 16'h0001;
	assign tb_ovf = s_r.tick_on && psc_pulse
		&& (({1'b0, s_r.tick_cnt} & tb_mask) == tb_mask);

	assign old_flags = {s_r.protect_req_flag, s_r.tick_req_flag, s_r.group_req_flag,
		s_r.src_flag, s_r.pt_flag};

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rdata = '0;
		s_nxt.vec_valid = 1'b0;
		s_nxt.div4 = s_r.div4 + 2'h1;
		if (s_r.tick_on && psc_pulse)
		begin
			s_nxt.tick_cnt = s_r.tick_cnt + 15'h0001;
		end
		if (i_return_from_irq)
		begin
			s_nxt.global_irq_en = 1'b1;
		end
		if (i_wr)
		begin
			case (i_addr)
				OFS_CTRL:
				begin
					{s_nxt.grp_en, s_nxt.tick_irq_en, s_nxt.protect_irq_en, s_nxt.global_irq_en} = i_wdata[6:0];
				end
				OFS_FLAGS:
				begin
					{s_nxt.group_req_flag, s_nxt.tick_req_flag, s_nxt.protect_req_flag} =
						{s_r.group_req_flag, s_r.tick_req_flag, s_r.protect_req_flag} & ~i_wdata[5:0];
				end
				OFS_SRC_FLAG: s_nxt.src_flag = s_r.src_flag & ~i_wdata;
				OFS_PT_FLAG: s_nxt.pt_flag = s_r.pt_flag & ~i_wdata[1:0];
				OFS_SRC_EN: s_nxt.src_en = i_wdata;
				OFS_PT_EN:
				begin
					{s_nxt.below_lower_cmp_en, s_nxt.above_upper_cmp_en, s_nxt.pt_en} = i_wdata[3:0];
				end
				OFS_UB_LO: s_nxt.upper_bound[7:0] = i_wdata;
				OFS_UB_HI: s_nxt.upper_bound[CONV_W-1:8] = i_wdata[3:0];
				OFS_LB_LO: s_nxt.lower_bound[7:0] = i_wdata;
				OFS_LB_HI: s_nxt.lower_bound[CONV_W-1:8] = i_wdata[3:0];
				OFS_TICK_CTRL:
				begin
					s_nxt.tick_on = i_wdata[7];
					s_nxt.tick_period_sel = i_wdata[2:0];
				end
				OFS_PSC_SRC: s_nxt.prescaler_src_sel = i_wdata[1:0];
				default: ;
			endcase
		end
		if (i_rd)
		begin
			case (i_addr)
				OFS_CTRL: s_nxt.rdata = {1'b0, s_r.grp_en, s_r.tick_irq_en, s_r.protect_irq_en, s_r.global_irq_en};
				OFS_FLAGS: s_nxt.rdata = {2'h0, s_r.group_req_flag, s_r.tick_req_flag, s_r.protect_req_flag};
				OFS_SRC_FLAG: s_nxt.rdata = s_r.src_flag;
				OFS_PT_FLAG: s_nxt.rdata = {6'h00, s_r.pt_flag};
				OFS_SRC_EN: s_nxt.rdata = s_r.src_en;
				OFS_PT_EN: s_nxt.rdata = {4'h0, s_r.below_lower_cmp_en, s_r.above_upper_cmp_en, s_r.pt_en};
				OFS_UB_LO: s_nxt.rdata = s_r.upper_bound[7:0];
				OFS_UB_HI: s_nxt.rdata = {4'h0, s_r.upper_bound[CONV_W-1:8]};
				OFS_LB_LO: s_nxt.rdata = s_r.lower_bound[7:0];
				OFS_LB_HI: s_nxt.rdata = {4'h0, s_r.lower_bound[CONV_W-1:8]};
				OFS_TICK_CTRL: s_nxt.rdata = {s_r.tick_on, 4'h0, s_r.tick_period_sel};
				OFS_PSC_SRC: s_nxt.rdata = {6'h00, s_r.prescaler_src_sel};
				default: s_nxt.rdata = '0;
			endcase
		end
		// Service takes the lowest pending index, passing over index 4 while both timer match flags are clear; the rest keep their flags.
		if (s_r.global_irq_en && !i_stack_full && (|pend))
		begin
			s_nxt.vec_valid = 1'b1;
			s_nxt.global_irq_en = 1'b0;
			if (pend[0])
			begin
				s_nxt.vec = VEC_PROT;
				s_nxt.protect_req_flag = 1'b0;
			end
			else if (pend[1])
			begin
				s_nxt.vec = VEC_GRP0;
				s_nxt.group_req_flag[0] = 1'b0;
			end
			else if (pend[2])
			begin
				s_nxt.vec = VEC_GRP0 + 3'h1;
				s_nxt.group_req_flag[1] = 1'b0;
			end
			else if (pend[3])
			begin
				s_nxt.vec = VEC_GRP2;
				s_nxt.group_req_flag[GRP_PWM] = 1'b0;
			end
			else if (pend[4] && (|s_r.pt_flag))
			begin
				s_nxt.vec = VEC_GRP2 + 3'h1;
				s_nxt.group_req_flag[GRP_PT] = 1'b0;
			end
			else if (pend[5])
			begin
				s_nxt.vec = VEC_TICK;
				s_nxt.tick_req_flag = 1'b0;
			end
			else
			begin
				s_nxt.vec_valid = 1'b0;
				s_nxt.global_irq_en = s_r.global_irq_en;
			end
		end
		// Sets come last so an event in the clearing cycle is never lost.
		if (i_motor_protect_signal)
		begin
			s_nxt.protect_req_flag = 1'b1;
		end
		if (tb_ovf)
		begin
			s_nxt.tick_req_flag = 1'b1;
		end
		s_nxt.src_flag = s_nxt.src_flag | src_set;
		s_nxt.pt_flag = s_nxt.pt_flag | {i_ptimer_p_match, i_ptimer_a_match};
		s_nxt.group_req_flag = s_nxt.group_req_flag | grp_set;
		new_flags = {s_nxt.protect_req_flag, s_nxt.tick_req_flag, s_nxt.group_req_flag,
			s_nxt.src_flag, s_nxt.pt_flag};
		s_nxt.wake = |(new_flags & ~old_flags);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_rdata = s_r.rdata;
	assign o_vector_valid = s_r.vec_valid;
	assign o_vector = s_r.vec;
	assign o_global_irq_en = s_r.global_irq_en;
	assign o_wake = s_r.wake;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	AST_PROT_SET: assert property (i_motor_protect_signal |=> s_r.protect_req_flag)
		else $error("protection flag not set");
	AST_VEC_GATED: assert property (s_r.vec_valid |-> $past(s_r.global_irq_en) && !$past(i_stack_full))
		else $error("vector without enable or with full stack");
	AST_SVC_EMI: assert property (s_r.vec_valid |-> !s_r.global_irq_en)
		else $error("global enable kept after service");
	AST_PROT_CLR: assert property (s_r.vec_valid && s_r.vec == VEC_PROT
		&& !$past(i_motor_protect_signal) |-> !s_r.protect_req_flag)
		else $error("protection flag kept after service");
	AST_SRC_KEEP: assert property (s_r.vec_valid && s_r.vec == VEC_GRP2 && !$past(i_wr)
		|-> (s_r.src_flag & $past(s_r.src_flag)) == $past(s_r.src_flag))
		else $error("source flags cleared by service");
	AST_RET_EN: assert property (i_return_from_irq && !i_wr |=> s_r.global_irq_en || s_r.vec_valid)
		else $error("return did not set global enable");
	AST_PSC_ZERO: assert property (i_rd && i_addr == OFS_PSC_SRC |=> o_rdata[7:2] == 6'h00)
		else $error("unimplemented prescaler bits nonzero");
	AST_WAKE: assert property ($rose(s_r.tick_req_flag) |-> s_r.wake)
		else $error("no wake on flag rise");
	AST_PRIO: assert property (s_r.vec_valid && s_r.vec != VEC_PROT
		|-> !$past(s_r.protect_req_flag && s_r.protect_irq_en))
		else $error("priority order broken");
	AST_TICK_RATE: assert property (s_r.tick_on && s_r.prescaler_src_sel == PSC_SYS
		&& s_r.tick_period_sel == 3'h0 && s_r.tick_cnt[7:0] == 8'hff |=> s_r.tick_req_flag)
		else $error("tick overflow missed");
	// Service checks look one cycle back, as the vector and the flag clear land on one edge.
	AST_GRP_SET: assert property ((|grp_set)
		|=> (s_r.group_req_flag & $past(grp_set)) == $past(grp_set))
		else $error("group flag not set by its source");
	AST_GRP_CLR: assert property (s_r.vec_valid && s_r.vec == VEC_GRP2
		&& !$past(grp_set[GRP_PWM]) |-> !s_r.group_req_flag[GRP_PWM])
		else $error("group flag kept after service");
	AST_TICK_CLR: assert property (s_r.vec_valid && s_r.vec == VEC_TICK
		&& !$past(tb_ovf) |-> !s_r.tick_req_flag)
		else $error("tick flag kept after service");
	AST_TICK_GATE: assert property (s_r.vec_valid && s_r.vec == VEC_TICK
		|-> $past(s_r.tick_req_flag && s_r.tick_irq_en))
		else $error("tick vector without flag and enable");
	AST_PT_FLAG: assert property (s_r.vec_valid && s_r.vec == VEC_GRP2 + 3'h1
		|-> $past(|s_r.pt_flag))
		else $error("timer vector without a match flag");
	AST_LATCH: assert property (!s_r.global_irq_en && s_r.protect_req_flag
		&& !(i_wr && i_addr == OFS_FLAGS) |=> s_r.protect_req_flag)
		else $error("latched flag lost");
	AST_FULL_HOLD: assert property (i_stack_full |=> !s_r.vec_valid)
		else $error("vector while stack full");
	AST_DIV4: assert property (s_r.tick_on && s_r.prescaler_src_sel == PSC_SYS_DIV4
		&& s_r.div4 != DIV4_LAST |=> $stable(s_r.tick_cnt))
		else $error("divided prescaler advanced early");
	AST_WAKE_PROT: assert property ($rose(s_r.protect_req_flag) |-> s_r.wake)
		else $error("no wake on protection flag rise");
	AST_LIMIT: assert property (limit_hit |=> s_r.src_flag[1])
		else $error("limit flag not set");
	AST_VEC_PULSE: assert property (s_r.vec_valid |=> !s_r.vec_valid)
		else $error("vector pulse longer than a cycle");
	AST_PT_SET: assert property (i_ptimer_p_match |=> s_r.pt_flag[1])
		else $error("timer match flag not set");
	AST_SRC_SET: assert property (i_capture_ovf |=> s_r.src_flag[2])
		else $error("capture overflow flag not set");

	COV_PROT: cover property (s_r.vec_valid && s_r.vec == VEC_PROT);
	COV_PWM: cover property (s_r.vec_valid && s_r.vec == VEC_GRP2);
	COV_TICK: cover property (s_r.vec_valid && s_r.vec == VEC_TICK);
	COV_STALL: cover property (s_r.global_irq_en && i_stack_full && (|pend));
	COV_TIMER: cover property (s_r.vec_valid && s_r.vec == VEC_GRP2 + 3'h1);
endmodule

//--- dv/core_stack_model.sv
// Behavioural model of the core's call stack and return path.
// Assumes the block's one-cycle vector pulse and a bench-issued return request.
`timescale 1ns/10ps
module core_stack_model #(
	parameter int DEPTH = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_vector_valid,
	input wire logic i_ret_req,
	output logic o_stack_full,
	output logic o_return_from_irq
);
	int cnt;
	// A depth of one lets a single unreturned service fill the stack.
	assign o_stack_full = (cnt >= DEPTH);
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt <= 0;
			o_return_from_irq <= 1'b0;
		end
		else
		begin
			o_return_from_irq <= i_ret_req && (cnt > 0);
			cnt <= cnt + int'(i_vector_valid) - int'(o_return_from_irq);
		end
	end
endmodule

//--- dv/tb_motor_mcu_irq_and_timebase.sv
// Self-checking bench for the interrupt and time base block.
// Assumes the strobed register port and the stack model on the core side.
`timescale 1ns/10ps
module tb_motor_mcu_irq_and_timebase;
	import irq_tb_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rdata;
	logic [9:0] ev = '0;
	logic [11:0] res = '0;
	logic full;
	logic return_from_irq;
	logic ret_req = 1'b0;
	logic sub_tick = 1'b0;
	logic vv;
	logic [VEC_W-1:0] vec;
	logic [VEC_W-1:0] last_vec = '0;
	logic gie;
	logic wake;
	logic [7:0] d;
	int error_cnt = 0;
	int n_compared = 0;
	int vec_cnt = 0;
	int wake_cnt = 0;
	int cyc = 0;
	int g;
	int v;

	always #4 clk = ~clk;

	irq_timebase i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_en),
		.i_rd(rd_en), .o_rdata(rdata), .i_motor_protect_signal(ev[0]), .i_conv_done(ev[1]),
		.i_conv_result(res), .i_capture_ovf(ev[2]), .i_capture_cmp(ev[3]), .i_pwm_period_match(ev[4]),
		.i_pwm_duty_match(ev[7:5]), .i_ptimer_a_match(ev[8]), .i_ptimer_p_match(ev[9]),
		.i_sub_clk_tick(sub_tick), .i_stack_full(full), .i_return_from_irq(return_from_irq), .o_vector_valid(vv),
		.o_vector(vec), .o_global_irq_en(gie), .o_wake(wake));
	core_stack_model #(.DEPTH(1)) i_core (.i_sys_clk(clk), .i_rst_n(rst_n), .i_vector_valid(vv),
		.i_ret_req(ret_req), .o_stack_full(full), .o_return_from_irq(return_from_irq));

	task print_verdict();
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// The whole run needs about 3500 cycles; the ceiling leaves ample margin.
	always @(posedge clk)
	begin
		cyc++;
		if (vv === 1'b1)
		begin
			vec_cnt++;
			last_vec = vec;
		end
		if (wake === 1'b1)
			wake_cnt++;
		if (cyc == 8000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task reg_wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge clk);
		addr <= a;
		wdata <= dat;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
		chk(d, exp);
	endtask

	task fire(input logic [9:0] e, input logic [11:0] r);
		@(posedge clk);
		ev <= e;
		res <= r;
		@(posedge clk);
		ev <= '0;
	endtask

	task ret();
		@(posedge clk);
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
	endtask

	task wait_vec(input int lim, input logic [VEC_W-1:0] exp);
		int n;
		n = vec_cnt;
		// Looking 1 ns after each edge keeps the count clear of the monitor's update.
		repeat (lim)
		begin
			if (vec_cnt == n)
			begin
				@(posedge clk);
				#1;
			end
		end
		chk(vec_cnt, n + 1);
		chk(last_vec, exp);
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(OFS_PSC_SRC, PSC_SRC_RESET);
		reg_wr(OFS_PSC_SRC, 8'hff);
		rd_chk(OFS_PSC_SRC, 8'h03);
		reg_wr(OFS_PSC_SRC, 8'h00);
		fire(10'h001, 12'h000);
		repeat (4) @(posedge clk);
		chk(wake_cnt, 1);
		chk(vec_cnt, 0);
		rd_chk(OFS_FLAGS, 8'h01);
		reg_wr(OFS_CTRL, 8'h03);
		wait_vec(10, VEC_PROT);
		chk(gie, 1'b0);
		rd_chk(OFS_FLAGS, 8'h00);
		reg_wr(OFS_CTRL, 8'h03);
		fire(10'h001, 12'h000);
		repeat (8) @(posedge clk);
		chk(vec_cnt, 1);
		ret();
		wait_vec(10, VEC_PROT);
		ret();
		repeat (3) @(posedge clk);
		chk(gie, 1'b1);
		// Both sources fire while the global enable is off, so they arrive together.
		reg_wr(OFS_CTRL, 8'h22);
		reg_wr(OFS_SRC_EN, 8'hff);
		fire(10'h011, 12'h000);
		reg_wr(OFS_CTRL, 8'h23);
		wait_vec(10, VEC_PROT);
		ret();
		wait_vec(10, VEC_GRP2);
		rd_chk(OFS_SRC_FLAG, 8'h10);
		reg_wr(OFS_SRC_FLAG, 8'h10);
		rd_chk(OFS_SRC_FLAG, 8'h00);
		ret();
		reg_wr(OFS_PT_EN, 8'h07);
		reg_wr(OFS_CTRL, 8'h79);
		for (int i = 1; i < 10; i++)
		begin
			g = (i >= 8) ? 3 : (i >= 4) ? 2 : (i >= 2) ? 1 : 0;
			fire(10'h001 << i, 12'h000);
			wait_vec(10, VEC_GRP0 + 3'(g));
			if (i < 8)
			begin
				rd_chk(OFS_SRC_FLAG, (i == 1) ? 8'h01 : 8'h01 << i);
				reg_wr(OFS_SRC_FLAG, 8'hff);
			end
			else
			begin
				rd_chk(OFS_PT_FLAG, 8'h01 << (i - 8));
				reg_wr(OFS_PT_FLAG, 8'hff);
			end
			ret();
		end
		reg_wr(OFS_UB_HI, 8'h01);
		fire(10'h002, 12'h200);
		wait_vec(10, VEC_GRP0);
		rd_chk(OFS_SRC_FLAG, 8'h03);
		reg_wr(OFS_SRC_FLAG, 8'h03);
		ret();
		reg_wr(OFS_PT_EN, 8'h0b);
		reg_wr(OFS_LB_LO, 8'h10);
		fire(10'h002, 12'h00f);
		wait_vec(10, VEC_GRP0);
		rd_chk(OFS_SRC_FLAG, 8'h03);
		reg_wr(OFS_SRC_FLAG, 8'h03);
		ret();
		reg_wr(OFS_CTRL, 8'h05);
		reg_wr(OFS_TICK_CTRL, 8'h80);
		v = vec_cnt;
		repeat (240) @(posedge clk);
		chk(vec_cnt, v);
		wait_vec(40, VEC_TICK);
		reg_wr(OFS_TICK_CTRL, 8'h00);
		rd_chk(OFS_FLAGS, 8'h00);
		// Any 512 sub clock pulses hold exactly one overflow at period code 1.
		ret();
		reg_wr(OFS_PSC_SRC, 8'h02);
		reg_wr(OFS_TICK_CTRL, 8'h81);
		v = vec_cnt;
		sub_tick <= 1'b1;
		repeat (512) @(posedge clk);
		sub_tick <= 1'b0;
		repeat (520) @(posedge clk);
		chk(vec_cnt, v + 1);
		rd_chk(OFS_FLAGS, 8'h00);
		ret();
		reg_wr(OFS_TICK_CTRL, 8'h80);
		reg_wr(OFS_PSC_SRC, 8'h01);
		wait_vec(1100, VEC_TICK);
		ret();
		v = vec_cnt;
		repeat (1000) @(posedge clk);
		chk(vec_cnt, v);
		wait_vec(40, VEC_TICK);
		print_verdict();
	end
endmodule
